// >>> src/chm_sequencer.sv
// Purpose: conversion sequencer, result store and configuration registers
// Assumes: serial_busy_i is high for the whole of every serial access
// Notes: the analog converter sits outside; it is started, halted and read here
module chm_sequencer
	import chm_pkg::*;
#(
	parameter int BIAS_CYC = BIAS_HALF_CYC
)
(
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	input  wire logic              serial_busy_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [7:0]        reg_wdata_i,
	output logic [7:0]             reg_rdata_o,
	input  wire logic              adc_done_i,
	input  wire logic [CODE_W-1:0] adc_code_i,
	output logic                   adc_start_o,
	output logic                   adc_halt_o,
	output logic [3:0]             adc_channel_o,
	output logic                   bias_high_o,
	output logic                   ref_power_o
);

	localparam logic [7:0] BIAS_LAST = 8'(BIAS_CYC - 1);

	chm_state_type     state_q;
	chm_state_type     state_d;
	logic [7:0]        cfg1_q;
	logic [7:0]        cfg2_q;
	logic [7:0]        offset_q;
	logic [CODE_W-1:0] res_q [NUM_CH];
	logic [CODE_W-1:0] code_q;
	logic [3:0]        cur_ch_q;
	logic [3:0]        rr_ptr_q;
	logic [7:0]        bias_cnt_q;

	logic              conv_en_w;
	logic              pair_w;
	logic              single_w;
	logic              avg_dis_w;
	logic [SEL_W-1:0]  sel_w;
	logic              go_w;
	logic [3:0]        single_ch_w;
	logic [3:0]        pick_ch_w;
	logic [3:0]        rr_ch_w;
	logic [3:0]        rr_next_w;
	logic              store_w;
	logic              ext_diode_w;
	logic              bias_run_w;
	logic [CODE_W-1:0] int_temp_w;
	logic              avg_valid_w;
	logic [CODE_W-1:0] avg_res_w;
	logic [7:0]        lsb03_w;
	logic [7:0]        lsb04_w;
	logic [7:0]        lsb05_w;
	logic              msb_hit_w;
	logic [3:0]        msb_idx_w;
	logic [7:0]        rdata_d;

	assign conv_en_w = cfg1_q[CFG1_EN_BIT];
	assign pair_w    = cfg1_q[CFG1_PAIR_BIT];
	assign single_w  = cfg2_q[CFG2_SINGLE_BIT];
	assign avg_dis_w = cfg2_q[CFG2_AVG_DIS_BIT];
	assign sel_w     = cfg2_q[CFG2_SEL_LSB +: SEL_W];
	// conversions only while enabled and the serial side is quiet
	assign go_w      = conv_en_w && !serial_busy_i;

	// out-of-range selects fall back to supply; AIN2 means the diode in sensor mode
	assign single_ch_w = (sel_w > CH_ANALOG_INPUT_EIGHT) ? CH_VDD :
	                     ((sel_w == CH_AIN2) && !pair_w) ? CH_EXT : sel_w;
	// pointer may rest on the second analog pin when the pins go back to sensor use
	assign rr_ch_w     = ((rr_ptr_q == CH_AIN2) && !pair_w) ? CH_AIN3 : rr_ptr_q;
	assign pick_ch_w   = single_w ? single_ch_w : rr_ch_w;

	assign rr_next_w = (cur_ch_q == CH_ANALOG_INPUT_EIGHT) ? CH_VDD :
	                   ((cur_ch_q == CH_EXT) && !pair_w) ? CH_AIN3 :
	                   cur_ch_q + 4'h1;

	assign store_w     = (state_q == ST_STORE);
	assign ext_diode_w = (cur_ch_q == CH_EXT) && !pair_w;
	assign bias_run_w  = (state_q == ST_WAIT) && ext_diode_w;
	assign int_temp_w  = code_q + {{(CODE_W - 8){offset_q[7]}}, offset_q};

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:  state_d = go_w ? ST_START : ST_IDLE;
			ST_START: state_d = go_w ? ST_WAIT : ST_IDLE;
			ST_WAIT:  state_d = !go_w ? ST_IDLE : (adc_done_i ? ST_STORE : ST_WAIT);
			ST_STORE: state_d = go_w ? ST_START : ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_q       <= ST_IDLE;
			cur_ch_q      <= CH_VDD;
			rr_ptr_q      <= CH_VDD;
			code_q        <= '0;
			adc_start_o   <= 1'b0;
			adc_halt_o    <= 1'b1;
			adc_channel_o <= CH_VDD;
			ref_power_o   <= 1'b0;
		end
		else
		begin
			state_q     <= state_d;
			adc_start_o <= (state_q == ST_START) && go_w;
			adc_halt_o  <= !go_w;
			ref_power_o <= conv_en_w;
			if ((state_q == ST_START) && go_w)
			begin
				cur_ch_q      <= pick_ch_w;
				adc_channel_o <= pick_ch_w;
			end
			if ((state_q == ST_WAIT) && adc_done_i)
				code_q <= adc_code_i;
			// a halted conversion is redone on the same channel
			if (store_w && !single_w)
				rr_ptr_q <= rr_next_w;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			bias_cnt_q  <= '0;
			bias_high_o <= 1'b0;
		end
		else if (!bias_run_w)
		begin
			bias_cnt_q  <= '0;
			bias_high_o <= 1'b0;
		end
		else if (bias_cnt_q == BIAS_LAST)
		begin
			bias_cnt_q  <= '0;
			bias_high_o <= !bias_high_o;
		end
		else
		begin
			bias_cnt_q <= bias_cnt_q + 8'h01;
		end
	end

	chm_avg u_avg
	(
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.clear_i     (!conv_en_w || pair_w),
		.bypass_i    (avg_dis_w),
		.in_valid_i  (store_w && ext_diode_w),
		.sample_i    (code_q),
		.out_valid_o (avg_valid_w),
		.result_o    (avg_res_w)
	);

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			for (int i = 0; i < NUM_CH; i++)
				res_q[i] <= '0;
		end
		else
		begin
			if (avg_valid_w)
				res_q[CH_EXT] <= avg_res_w;
			if (store_w && (cur_ch_q == CH_INT))
				res_q[CH_INT] <= int_temp_w;
			else if (store_w && !ext_diode_w)
				res_q[cur_ch_q] <= code_q;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cfg1_q   <= CFG1_RESET;
			cfg2_q   <= CFG2_RESET;
			offset_q <= OFFSET_RESET;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == ADDR_CFG1)
				cfg1_q <= reg_wdata_i;
			if (reg_addr_i == ADDR_CFG2)
				cfg2_q <= reg_wdata_i;
			if (reg_addr_i == ADDR_INT_OFFSET)
				offset_q <= reg_wdata_i;
		end
	end

	assign lsb03_w = {4'h0, res_q[CH_INT][1:0], res_q[CH_VDD][1:0]};

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_lsb
			assign lsb04_w[2*g +: 2] = res_q[CH_EXT + g][1:0];
			assign lsb05_w[2*g +: 2] = res_q[CH_AIN3 + 2 + g][1:0];
		end
	endgenerate

	assign msb_hit_w = (reg_addr_i >= ADDR_MSB_BASE) && (reg_addr_i <= ADDR_MSB_LAST);
	assign msb_idx_w = reg_addr_i[3:0] - ADDR_MSB_BASE[3:0];

	assign rdata_d = msb_hit_w                      ? res_q[msb_idx_w][CODE_W-1:2] :
	                 (reg_addr_i == ADDR_LSB_INT_VDD) ? lsb03_w :
	                 (reg_addr_i == ADDR_LSB_EXT)     ? lsb04_w :
	                 (reg_addr_i == ADDR_LSB_AIN)     ? lsb05_w :
	                 (reg_addr_i == ADDR_CFG1)        ? cfg1_q :
	                 (reg_addr_i == ADDR_CFG2)        ? cfg2_q :
	                 (reg_addr_i == ADDR_INT_OFFSET)  ? offset_q : 8'h00;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			reg_rdata_o <= rdata_d;
	end

	// checking aids: last started channel and whether it finished
	logic [3:0] last_ch_q;
	logic       last_done_q;
	logic       last_rr_q;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			last_ch_q   <= CH_VDD;
			last_done_q <= 1'b0;
			last_rr_q   <= 1'b0;
		end
		else if (adc_start_o)
		begin
			last_ch_q   <= adc_channel_o;
			last_done_q <= 1'b0;
			last_rr_q   <= !single_w;
		end
		else if (store_w)
		begin
			last_done_q <= 1'b1;
		end
	end

	sequence s_done_quiet;
		(state_q == ST_WAIT) && adc_done_i && go_w ##1 go_w [*2];
	endsequence

	property p_back_to_back;
		@(posedge clk_i) disable iff (!resetn_i)
		s_done_quiet |=> adc_start_o;
	endproperty
	a_back_to_back: assert property (p_back_to_back) else $error("no restart after conversion");

	property p_busy_halts;
		@(posedge clk_i) disable iff (!resetn_i)
		serial_busy_i |=> adc_halt_o && !adc_start_o;
	endproperty
	a_busy_halts: assert property (p_busy_halts) else $error("conversion ran during serial access");

	property p_disabled_idle;
		@(posedge clk_i) disable iff (!resetn_i)
		!conv_en_w |=> !adc_start_o && !ref_power_o;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("activity while monitoring disabled");

	property p_ref_power;
		@(posedge clk_i) disable iff (!resetn_i)
		##1 (ref_power_o == $past(conv_en_w));
	endproperty
	a_ref_power: assert property (p_ref_power) else $error("reference power does not follow enable");

	property p_wrap;
		@(posedge clk_i) disable iff (!resetn_i)
		(adc_start_o && !single_w && last_rr_q && last_done_q && (last_ch_q == CH_ANALOG_INPUT_EIGHT)) |-> (adc_channel_o == CH_VDD);
	endproperty
	a_wrap: assert property (p_wrap) else $error("round robin did not wrap to supply");

	property p_rr_order;
		@(posedge clk_i) disable iff (!resetn_i)
		(adc_start_o && !single_w && last_rr_q && last_done_q && (last_ch_q == CH_VDD)) |-> (adc_channel_o == CH_INT);
	endproperty
	a_rr_order: assert property (p_rr_order) else $error("internal channel did not follow supply");

	property p_single_int;
		@(posedge clk_i) disable iff (!resetn_i)
		(adc_start_o && single_w && (sel_w == CH_INT)) |-> (adc_channel_o == CH_INT);
	endproperty
	a_single_int: assert property (p_single_int) else $error("single mode missed internal channel");

	property p_int_offset;
		@(posedge clk_i) disable iff (!resetn_i)
		(store_w && (cur_ch_q == CH_INT)) |=> (res_q[CH_INT] == $past(code_q) + {{2{$past(offset_q[7])}}, $past(offset_q)});
	endproperty
	a_int_offset: assert property (p_int_offset) else $error("internal result lacks offset");

	property p_bias_idle;
		@(posedge clk_i) disable iff (!resetn_i)
		!bias_run_w |=> !bias_high_o;
	endproperty
	a_bias_idle: assert property (p_bias_idle) else $error("bias raised outside diode conversion");

	property p_pair_skip;
		@(posedge clk_i) disable iff (!resetn_i)
		(adc_start_o && !single_w && !pair_w && last_rr_q && last_done_q && (last_ch_q == CH_EXT))
			|-> (adc_channel_o == CH_AIN3);
	endproperty
	a_pair_skip: assert property (p_pair_skip) else $error("sensor pins converted as two inputs");

	property p_single_vdd;
		@(posedge clk_i) disable iff (!resetn_i)
		(adc_start_o && single_w && (sel_w == CH_VDD)) |-> (adc_channel_o == CH_VDD);
	endproperty
	a_single_vdd: assert property (p_single_vdd) else $error("zero select missed supply channel");

	property p_sel_fallback;
		@(posedge clk_i) disable iff (!resetn_i)
		(adc_start_o && single_w && (sel_w > CH_ANALOG_INPUT_EIGHT)) |-> (adc_channel_o == CH_VDD);
	endproperty
	a_sel_fallback: assert property (p_sel_fallback) else $error("unused select did not fall back");

	property p_supply_raw;
		@(posedge clk_i) disable iff (!resetn_i)
		(store_w && (cur_ch_q == CH_VDD)) |=> (res_q[CH_VDD] == $past(code_q));
	endproperty
	a_supply_raw: assert property (p_supply_raw) else $error("supply code altered on store");

	// busy sampled high, then two quiet enabled cycles
	sequence s_access_end;
		serial_busy_i ##1 go_w [*2];
	endsequence

	property p_resume;
		@(posedge clk_i) disable iff (!resetn_i)
		s_access_end |=> adc_start_o;
	endproperty
	a_resume: assert property (p_resume) else $error("no restart after serial access");

endmodule : chm_sequencer

// >>> shared/chm_pkg.sv
// Purpose: constants, register map and types of the channel measurement sequencer
// Assumes: 10 MHz clk_i, byte-wide register port driven by the serial interface logic
// Notes: Function
// Function
// - reset selects round robin, monitoring off
// - conversion enable bit starts the measurements
// - order: supply, internal, external/pair, inputs three-eight
// - after input eight wrap to supply
// - single channel bit disables round robin
// - select field picks channel; zero is supply
// - select value one picks internal temperature
// - single mode converts back to back
// - serial access halts, then conversions resume
// - reference powered only while monitoring
// - internal temperature stored twos complement
// - offset register added to internal temperature
// - external temperature is 10-bit twos complement
// - external temperature averaged over 16 samples
// - supply code unsigned 10-bit, stored unchanged
// - diode bias toggles between base and N-fold
// - diode pins: sensor or two analog inputs
// - bit five disables averaging, enabled at reset
// - supply LSBs at 03h, MSBs at 06h
package chm_pkg;

	localparam logic [7:0] ADDR_LSB_INT_VDD = 8'h03;
	localparam logic [7:0] ADDR_LSB_EXT     = 8'h04;
	localparam logic [7:0] ADDR_LSB_AIN     = 8'h05;
	localparam logic [7:0] ADDR_MSB_BASE    = 8'h06;
	localparam logic [7:0] ADDR_MSB_LAST    = 8'h0F;
	localparam logic [7:0] ADDR_CFG1        = 8'h18;
	localparam logic [7:0] ADDR_CFG2        = 8'h19;
	localparam logic [7:0] ADDR_INT_OFFSET  = 8'h1D;

	localparam logic [7:0] CFG1_RESET       = 8'h00;
	localparam logic [7:0] CFG2_RESET       = 8'h00;
	localparam logic [7:0] OFFSET_RESET     = 8'h00;

	localparam int CFG1_EN_BIT      = 0;
	localparam int CFG1_PAIR_BIT    = 3;
	localparam int CFG2_SEL_LSB     = 0;
	localparam int SEL_W            = 4;
	localparam int CFG2_SINGLE_BIT  = 4;
	localparam int CFG2_AVG_DIS_BIT = 5;

	localparam int CODE_W = 10;
	localparam int NUM_CH = 10;

	localparam logic [3:0] CH_VDD  = 4'h0;
	localparam logic [3:0] CH_INT  = 4'h1;
	localparam logic [3:0] CH_EXT  = 4'h2;
	localparam logic [3:0] CH_AIN2 = 4'h3;
	localparam logic [3:0] CH_AIN3 = 4'h4;
	localparam logic [3:0] CH_ANALOG_INPUT_EIGHT = 4'h9;

	localparam int AVG_SAMPLES = 16;
	localparam int AVG_SHIFT   = 4;

	localparam int CLK_PERIOD_NS = 100;
	localparam int BIAS_HALF_NS  = 1000;
	localparam int BIAS_HALF_CYC = (BIAS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_WAIT  = 2'b11,
		ST_STORE = 2'b10
	} chm_state_type;

endpackage : chm_pkg

// >>> src/chm_avg.sv
// Purpose: 16-sample averager for signed temperature codes
// Assumes: samples arrive as single-cycle in_valid_i pulses
// Notes: result follows the last sample by one cycle
module chm_avg
	import chm_pkg::*;
#(
	parameter int W       = CODE_W,
	parameter int SAMPLES = AVG_SAMPLES,
	parameter int SHIFT   = AVG_SHIFT
)
(
	input  wire logic                clk_i,
	input  wire logic                resetn_i,
	input  wire logic                clear_i,
	input  wire logic                bypass_i,
	input  wire logic                in_valid_i,
	input  wire logic signed [W-1:0] sample_i,
	output logic                     out_valid_o,
	output logic signed [W-1:0]      result_o
);

	localparam int SW = W + SHIFT;
	localparam logic [SHIFT-1:0] CNT_LAST = SHIFT'(SAMPLES - 1);

	logic signed [SW-1:0] sum_q;
	logic [SHIFT-1:0]     cnt_q;
	logic signed [SW-1:0] sum_next;
	logic                 last_w;

	assign sum_next = sum_q + SW'(sample_i);
	assign last_w   = (cnt_q == CNT_LAST);

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sum_q       <= '0;
			cnt_q       <= '0;
			out_valid_o <= 1'b0;
			result_o    <= '0;
		end
		else if (clear_i || (bypass_i && in_valid_i))
		begin
			sum_q       <= '0;
			cnt_q       <= '0;
			// a clear on its own must not publish a raw sample as an average
			out_valid_o <= bypass_i && in_valid_i;
			result_o    <= (bypass_i && in_valid_i) ? sample_i : result_o;
		end
		else if (in_valid_i)
		begin
			// arithmetic shift keeps the twos-complement sign
			sum_q       <= last_w ? '0 : sum_next;
			cnt_q       <= cnt_q + 1'b1;
			out_valid_o <= last_w;
			result_o    <= last_w ? W'(sum_next >>> SHIFT) : result_o;
		end
		else
		begin
			out_valid_o <= 1'b0;
		end
	end

	property p_avg_after_16;
		@(posedge clk_i) disable iff (!resetn_i)
		(in_valid_i && !bypass_i && !clear_i && !last_w) |=> !out_valid_o;
	endproperty
	a_avg_after_16: assert property (p_avg_after_16) else $error("average emitted before 16 samples");

	property p_avg_emit;
		@(posedge clk_i) disable iff (!resetn_i)
		(in_valid_i && !bypass_i && !clear_i && last_w) |=> out_valid_o;
	endproperty
	a_avg_emit: assert property (p_avg_emit) else $error("average missing after 16 samples");

endmodule : chm_avg

// >>> tb/chm_adc_model.sv
// Purpose: behavioural converter answering the sequencer's start pulses
// Assumes: one conversion at a time; halt level aborts it at once
// Notes: latency varies from prompt to slow; code line shows junk outside done
module chm_adc_model
	import chm_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	input  wire logic              start_i,
	input  wire logic              halt_i,
	output logic                   done_o,
	output logic [CODE_W-1:0]      code_o
);
	timeunit 1ns;
	timeprecision 1ns;

	int                wait_q;
	logic [CODE_W-1:0] last_q;
	logic [CODE_W-1:0] next_code;

	always @(posedge clk_i)
		next_code <= 10'($urandom);

	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wait_q <= 0;
			done_o <= 1'b0;
			code_o <= 10'h155;
			last_q <= 10'h000;
		end
		else
		begin
			done_o <= 1'b0;
			// inverse of last code so a late sample never matches by luck
			code_o <= ~last_q;
			if (halt_i)
				wait_q <= 0;
			else if (start_i)
				wait_q <= 2 + $urandom_range(7);
			else if (wait_q == 1)
			begin
				last_q <= next_code;
				code_o <= next_code;
				done_o <= 1'b1;
				wait_q <= 0;
			end
			else if (wait_q > 1)
				wait_q <= wait_q - 1;
		end
	end
endmodule : chm_adc_model

// >>> tb/channel_measurement_sequencer_test.sv
// Purpose: self-checking bench of the measurement sequencer
// Assumes: converter model chm_adc_model, short bias period
// Notes: results are read back only with monitoring stopped
module channel_measurement_sequencer_test;
	import chm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic       clk_i = 0, resetn_i = 0, busy = 0, wr = 0, rd = 0;
	logic       done, halt, start, bias, refp;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, off, rm;
	logic [9:0] code, res [NUM_CH];
	logic [3:0] chan;
	logic [3:0] starts [$];
	int         fails = 0, total_checks = 0, cycles = 0, n = 0;
	int         avg_n = 0, avg_sum = 0, done_cyc = 0, gap = 0;
	bit         bias_seen = 0;

	chm_sequencer #(.BIAS_CYC(2)) dut
	(
		.clk_i(clk_i), .resetn_i(resetn_i), .serial_busy_i(busy),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .adc_done_i(done), .adc_code_i(code),
		.adc_start_o(start), .adc_halt_o(halt), .adc_channel_o(chan),
		.bias_high_o(bias), .ref_power_o(refp)
	);

	chm_adc_model adc
	(
		.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start),
		.halt_i(halt), .done_o(done), .code_o(code)
	);

	always #50 clk_i = ~clk_i;

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			finish_test();
		end
		// done during a serial access is discarded by the sequencer
		if (done && !busy)
		begin
			res[chan] = code;
			done_cyc = cycles;
			if (chan == CH_EXT)
			begin
				avg_sum += int'($signed(code));
				avg_n++;
			end
		end
		if (start)
		begin
			starts.push_back(chan);
			gap = cycles - done_cyc;
		end
		if (bias)
			bias_seen = 1;
	end

	function automatic logic [9:0] exp_int(input logic [9:0] c, input logic [7:0] o);
		return c + {{2{o[7]}}, o};
	endfunction : exp_int

	// round robin successor with the diode pins used as a sensor
	function automatic logic [3:0] exp_rr(input logic [3:0] c);
		if (c == CH_ANALOG_INPUT_EIGHT)
			return CH_VDD;
		return (c == CH_EXT) ? CH_AIN3 : c + 4'h1;
	endfunction : exp_rr

	// single mode channel for a select value, sensor pins
	function automatic logic [3:0] exp_single(input logic [3:0] s);
		if (s > CH_ANALOG_INPUT_EIGHT)
			return CH_VDD;
		return (s == CH_AIN2) ? CH_EXT : s;
	endfunction : exp_single

	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#10;
	endtask : tick

	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		busy = 1;
		tick(1);
		{wr, addr, wdata} = {1'b1, a, d};
		tick(1);
		wr = 0;
		tick(1);
		busy = 0;
		tick(1);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		busy = 1;
		tick(1);
		{rd, addr} = {1'b1, a};
		tick(1);
		rd = 0;
		v = rdata;
		tick(1);
		busy = 0;
		tick(1);
	endtask : rd_reg

	task automatic read_res(input int ch, input logic [9:0] exp);
		logic [7:0] m, l;
		rd_reg(8'(ADDR_MSB_BASE + ch), m);
		rd_reg(8'(ADDR_LSB_INT_VDD + (ch + 2) / 4), l);
		check({m, 2'(l >> (ch < 2 ? 2 * ch : 2 * ((ch - 2) % 4)))}, exp);
	endtask : read_res

	task automatic expect_starts(input logic [3:0] ch);
		starts.delete();
		while (starts.size() < 4)
			@(posedge clk_i);
		#10;
		foreach (starts[i])
			check(starts[i], ch);
		check(10'(gap), 10'h003);
	endtask : expect_starts

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	initial
	begin
		void'($urandom(12545));
		off = 8'($urandom);
		tick(4);
		resetn_i = 1;
		rd_reg(ADDR_CFG1, rm);
		check(rm, CFG1_RESET);
		rd_reg(ADDR_CFG2, rm);
		check(rm, CFG2_RESET);
		tick(20);
		check(10'(starts.size()), 10'h000);
		check({refp, halt}, 2'b01);
		rd_reg(8'hFE, rm);
		check(rm, 8'h00);
		// analog pin mode: every channel converted, all but internal stored raw
		wr_reg(ADDR_INT_OFFSET, off);
		wr_reg(ADDR_CFG1, 8'h09);
		while (starts.size() < 11)
			@(posedge clk_i);
		#10;
		check(refp, 1'b1);
		for (int i = 0; i < 11; i++)
			check(starts[i], 10'(i % 10));
		wr_reg(ADDR_CFG1, 8'h00);
		check({refp, halt}, 2'b01);
		for (int ch = 0; ch < NUM_CH; ch++)
			read_res(ch, ch == 1 ? exp_int(res[1], off) : res[ch]);
		// diode pins as sensor: second analog pin skipped
		wr_reg(ADDR_CFG1, 8'h01);
		starts.delete();
		while (starts.size() < 12)
			@(posedge clk_i);
		#10;
		for (int i = 0; i < 11; i++)
			check(starts[i + 1], exp_rr(starts[i]));
		wr_reg(ADDR_CFG2, 8'h10);
		wr_reg(ADDR_CFG1, 8'h01);
		expect_starts(CH_VDD);
		wr_reg(ADDR_CFG2, 8'h11);
		expect_starts(CH_INT);
		tick(1);
		busy = 1;
		tick(2);
		check(halt, 1'b1);
		n = starts.size();
		busy = 0;
		tick(6);
		check(starts.size() > n, 1'b1);
		check(starts[$], CH_INT);
		repeat (2)
		begin
			rm = 8'h10 | (8'($urandom) & 8'h0F);
			wr_reg(ADDR_CFG2, rm);
			expect_starts(exp_single(rm[3:0]));
		end
		// diode sensor mode, averaging on
		wr_reg(ADDR_CFG1, 8'h00);
		wr_reg(ADDR_CFG2, 8'h12);
		avg_n = 0;
		avg_sum = 0;
		bias_seen = 0;
		wr_reg(ADDR_CFG1, 8'h01);
		while (avg_n < 16)
			@(posedge clk_i);
		tick(3);
		wr_reg(ADDR_CFG1, 8'h00);
		read_res(CH_EXT, 10'(avg_sum >>> 4));
		check(bias_seen, 1'b1);
		wr_reg(ADDR_CFG2, 8'h32);
		rd_reg(ADDR_CFG2, rm);
		check(rm, 8'h32);
		avg_n = 0;
		wr_reg(ADDR_CFG1, 8'h01);
		while (avg_n < 1)
			@(posedge clk_i);
		tick(3);
		wr_reg(ADDR_CFG1, 8'h00);
		read_res(CH_EXT, res[CH_EXT]);
		// reset in mid run: back to round robin, monitoring off
		wr_reg(ADDR_CFG1, 8'h01);
		tick(7);
		resetn_i = 0;
		tick(2);
		check({refp, halt, start, bias}, 4'b0100);
		resetn_i = 1;
		n = starts.size();
		tick(20);
		check(starts.size() == n, 1'b1);
		rd_reg(ADDR_CFG2, rm);
		check(rm, CFG2_RESET);
		finish_test();
	end
endmodule : channel_measurement_sequencer_test
